// File: core/product_term_macrocell_block.sv
// Sixteen product-term macrocells with expanders, configured over classic Wishbone
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "pterm_regs_regs.svh"

module product_term_macrocell_block
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // Wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [11:0]            adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire pterm_pkg::word_t       dat_i,
    output pterm_pkg::word_t            dat_o,
    output logic                        ack_o,
    // Routing inputs and control sources
    input  wire logic [31:0]            routeIn,
    input  wire logic [3:0]             dedicatedClk,
    input  wire logic                   globalClk,
    input  wire logic [1:0]             localClk,
    input  wire logic [1:0]             blockClockEnable,
    input  wire logic                   globalClr,
    input  wire logic [1:0]             localClr,
    input  wire logic                   deviceWideReset_n,
    // Macrocell outputs back to routing
    output logic [15:0]                 mcOut
);
    import pterm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers; stage one is read only by stage two
    localparam int SW = 32 + 4 + 1 + 2 + 2 + 1 + 2 + 1;
    logic [SW-1:0] syncA_q;
    logic [SW-1:0] syncB_q;
    logic [31:0]   inSync;
    logic [3:0]    dedSync;
    logic          globClkSync;
    logic [1:0]    locClkSync;
    logic [1:0]    enaSync;
    logic          globClrSync;
    logic [1:0]    locClrSync;
    logic          rstNSync;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            syncA_q <= '0;
            syncB_q <= '0;
        end
        else
        begin
            syncA_q <= {routeIn, dedicatedClk, globalClk, localClk, blockClockEnable,
                        globalClr, localClr, deviceWideReset_n};
            syncB_q <= syncA_q;
        end
    end

    assign {inSync, dedSync, globClkSync, locClkSync, enaSync,
            globClrSync, locClrSync, rstNSync} = syncB_q;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration storage
    word_t trueMask_q [`NUM_TERM];
    word_t compMask_q [`NUM_TERM];
    word_t mcCtrl_q   [`NUM_MC];
    word_t blkCtrl_q;
    logic  ack_q;
    word_t datOut_q;
    logic  reqNew;
    logic  wrDo;
    logic  selTrue;
    logic  selComp;
    logic  selMc;
    logic  selBlk;
    logic  selStat;
    logic [4:0] termIdx;
    logic [3:0] mcIdx;
    word_t readMux;
    word_t statusWord;
    logic [15:0] mcOut_q;
    logic [1:0]  clrAct;
    logic [1:0]  clkLvl;

    function automatic word_t merge(input word_t oldV, input word_t newV, input logic [3:0] be);
        word_t r;
        r = oldV;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = newV[b*8 +: 8];
        return r;
    endfunction

    assign termIdx = adr_i[6:2];
    assign mcIdx   = adr_i[5:2];
    assign selTrue = (adr_i[11:7] == 5'(`OFS_TRUE >> 7));
    assign selComp = (adr_i[11:7] == 5'(`OFS_COMP >> 7));
    assign selMc   = (adr_i[11:6] == 6'(`OFS_MC >> 6));
    assign selBlk  = (adr_i[11:2] == 10'(`OFS_BLK >> 2));
    assign selStat = (adr_i[11:2] == 10'(`OFS_STAT >> 2));
    assign reqNew  = cyc_i & stb_i & ~ack_q;
    // Write lands on the edge where the master sees ack
    assign wrDo    = cyc_i & stb_i & we_i & ack_q;

    assign statusWord = {12'h000, clkLvl, clrAct, mcOut_q};

    always_comb
    begin
        readMux = 32'h00000000;
        if (selTrue)
            readMux = trueMask_q[termIdx];
        else if (selComp)
            readMux = compMask_q[termIdx];
        else if (selMc)
            readMux = mcCtrl_q[mcIdx];
        else if (selBlk)
            readMux = blkCtrl_q;
        else if (selStat)
            readMux = statusWord;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_q    <= 1'b0;
            datOut_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= reqNew;
            if (reqNew)
                datOut_q <= readMux;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = datOut_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < `NUM_TERM; k++)
            begin
                trueMask_q[k] <= `MASK_RST;
                compMask_q[k] <= `MASK_RST;
            end
        end
        else if (wrDo && selTrue)
            trueMask_q[termIdx] <= merge(trueMask_q[termIdx], dat_i, sel_i);
        else if (wrDo && selComp)
            compMask_q[termIdx] <= merge(compMask_q[termIdx], dat_i, sel_i);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int k = 0; k < `NUM_MC; k++)
                mcCtrl_q[k] <= `MC_RST;
            blkCtrl_q <= `BLK_RST;
        end
        else if (wrDo && selMc)
            mcCtrl_q[mcIdx] <= merge(mcCtrl_q[mcIdx], dat_i, sel_i);
        else if (wrDo && selBlk)
            blkCtrl_q <= merge(blkCtrl_q, dat_i, sel_i);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block clocks, enables and clears
    logic [1:0] clkPrev_q;
    logic [1:0] tick;
    logic       devRst;

    function automatic logic pickClk(input clkSrc_t s, input logic [3:0] ded,
                                     input logic glob, input logic loc);
        logic r;
        r = 1'b0;
        case (s)
            SRC_DED0, SRC_DED1, SRC_DED2, SRC_DED3: r = ded[s[1:0]];
            SRC_GLOBAL:                             r = glob;
            SRC_LOCAL:                              r = loc;
            default:                                r = 1'b0;
        endcase
        return r;
    endfunction

    assign clkLvl[0] = pickClk(clkSrc_t'(blkCtrl_q[`BLK_BLOCK_CLOCK_ONE_LSB +: 3]), dedSync, globClkSync, locClkSync[0]);
    assign clkLvl[1] = pickClk(clkSrc_t'(blkCtrl_q[`BLK_CLK2_LSB +: 3]), dedSync, globClkSync, locClkSync[1]);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            clkPrev_q <= 2'h0;
        else
            clkPrev_q <= clkLvl;
    end

    // Each clock picks its own edge, so mixed edges need both clocks
    assign tick[0] = (blkCtrl_q[`BLK_BLOCK_CLOCK_ONE_FALL] ? (clkPrev_q[0] & ~clkLvl[0])
                                                : (~clkPrev_q[0] & clkLvl[0])) & enaSync[0];
    assign tick[1] = (blkCtrl_q[`BLK_CLK2_FALL] ? (clkPrev_q[1] & ~clkLvl[1])
                                                : (~clkPrev_q[1] & clkLvl[1])) & enaSync[1];

    assign clrAct[0] = (blkCtrl_q[`BLK_BLOCK_ASYNC_CLEAR_ONE_LOC] ? locClrSync[0] : globClrSync)
                       ^ blkCtrl_q[`BLK_BLOCK_ASYNC_CLEAR_ONE_INV];
    assign clrAct[1] = (blkCtrl_q[`BLK_BLOCK_ASYNC_CLEAR_TWO_LOC] ? locClrSync[1] : globClrSync)
                       ^ blkCtrl_q[`BLK_BLOCK_ASYNC_CLEAR_TWO_INV];

    assign devRst = blkCtrl_q[`BLK_DRST_EN] & ~rstNSync;

    ////////////////////////////////////////////////////////////////////////////
    // Product terms; feedback taken from output flops to avoid loops
    logic [31:0] lit;
    logic [31:0] term;

    genvar g;
    generate
        for (g = 0; g < `NUM_IN; g++)
        begin : gLit
            if (g < `NUM_FB)
                assign lit[g] = blkCtrl_q[`BLK_FB_LSB + g] ? mcOut_q[g] : inSync[g];
            else
                assign lit[g] = inSync[g];
            // Empty masks give a constant one
            assign term[g] = &(~trueMask_q[g] | lit) & &(~compMask_q[g] | ~lit);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Macrocells with expander chain toward lower indices
    logic [16:0] expSum;
    logic [15:0] mcReg_q;
    logic [15:0] mcComb;

    assign expSum[16] = 1'b0;

    generate
        for (g = 0; g < `NUM_MC; g++)
        begin : gMc
            word_t     c;
            logic      t0;
            logic      t1;
            logic      prim0;
            logic      prim1;
            logic      borrowed;
            logic      sumA;
            logic      sumB;
            logic      sumAll;
            logic      clr;
            logic      tk;
            logic      nxt;
            regType_t  rt;
            clrSel_t   cs;

            assign c  = mcCtrl_q[g];
            assign rt = regType_t'(c[`MC_TYPE_LSB +: 2]);
            assign cs = clrSel_t'(c[`MC_CLR_LSB +: 2]);
            // Two own terms per macrocell
            assign t0 = term[2*g]   ^ (c[`MC_INV_EN] & ~c[`MC_INV_SEL]);
            assign t1 = term[2*g+1] ^ (c[`MC_INV_EN] &  c[`MC_INV_SEL]);
            assign prim0 = t0 & ~c[`MC_LEND0];
            assign prim1 = t1 & ~c[`MC_LEND1];
            // Each link adds one group of two; fifteen neighbours give thirty terms
            assign expSum[g] = (t0 & c[`MC_LEND0]) | (t1 & c[`MC_LEND1])
                               | (c[`MC_PASS] & expSum[g+1]);
            assign borrowed = c[`MC_BORROW] & expSum[g+1];
            assign sumAll = (prim0 | prim1 | borrowed) ^ c[`MC_POL];
            // JK and SR: first input from term zero and expanders, second from term one
            assign sumA = (prim0 | borrowed) ^ c[`MC_POL];
            assign sumB = prim1;
            assign tk   = c[`MC_CLKSEL] ? tick[1] : tick[0];

            always_comb
            begin
                case (cs)
                    CLR_ONE: clr = clrAct[0];
                    CLR_TWO: clr = clrAct[1];
                    default: clr = 1'b0;
                endcase
            end

            always_comb
            begin
                case (rt)
                    REG_D:   nxt = sumAll;
                    REG_T:   nxt = mcReg_q[g] ^ sumAll;
                    REG_JK:  nxt = (sumA & ~mcReg_q[g]) | (~sumB & mcReg_q[g]);
                    REG_SR:  nxt = (sumA & ~sumB) | (~(sumB & ~sumA) & mcReg_q[g]);
                    default: nxt = mcReg_q[g];
                endcase
            end

            always_ff @(posedge core_clk)
            begin
                if (sys_rst || devRst)
                    mcReg_q[g] <= 1'b0;
                else if (clr)
                    mcReg_q[g] <= 1'b0;
                else if (tk)
                    mcReg_q[g] <= nxt;
            end

            // Clear also masks the registered output in the cycle it arrives; bypassed sums are not masked
            assign mcComb[g] = c[`MC_BYPASS] ? sumAll : (mcReg_q[g] & ~clr & ~devRst);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Output flops; adds one cycle to bypassed paths
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mcOut_q <= 16'h0000;
        else
            mcOut_q <= mcComb;
    end

    assign mcOut = mcOut_q;

endmodule

// File: core/pterm_regs_regs.svh
// Register offsets, field positions, reset values and sizes of the macrocell block
`ifndef PTERM_REGS_REGS_SVH
`define PTERM_REGS_REGS_SVH

// Sizes
`define NUM_MC        16
`define NUM_IN        32
`define NUM_TERM      32
`define NUM_FB        9
`define NUM_DED       4

// Byte offsets on the bus
`define OFS_TRUE      12'h000
`define OFS_COMP      12'h080
`define OFS_MC        12'h100
`define OFS_BLK       12'h140
`define OFS_STAT      12'h144

// Macrocell control fields
`define MC_TYPE_LSB   0
`define MC_BYPASS     2
`define MC_CLKSEL     3
`define MC_CLR_LSB    4
`define MC_LEND0      6
`define MC_LEND1      7
`define MC_INV_EN     8
`define MC_INV_SEL    9
`define MC_BORROW     10
`define MC_PASS       11
`define MC_POL        12

// Block control fields
`define BLK_BLOCK_CLOCK_ONE_LSB  0
`define BLK_BLOCK_CLOCK_ONE_FALL 3
`define BLK_CLK2_LSB  4
`define BLK_CLK2_FALL 7
`define BLK_BLOCK_ASYNC_CLEAR_ONE_LOC  8
`define BLK_BLOCK_ASYNC_CLEAR_ONE_INV  9
`define BLK_BLOCK_ASYNC_CLEAR_TWO_LOC  10
`define BLK_BLOCK_ASYNC_CLEAR_TWO_INV  11
`define BLK_DRST_EN   12
`define BLK_FB_LSB    16

// Reset values
`define MASK_RST      32'h00000000
`define MC_RST        32'h00000000
`define BLK_RST       32'h00000000

`endif

// File: core/pterm_pkg.sv
// Types shared by the macrocell block
package pterm_pkg;
    typedef enum logic [1:0] {REG_D, REG_T, REG_JK, REG_SR} regType_t;
    typedef enum logic [1:0] {CLR_NONE, CLR_ONE, CLR_TWO, CLR_OFF} clrSel_t;
    typedef enum logic [2:0] {SRC_DED0, SRC_DED1, SRC_DED2, SRC_DED3,
                              SRC_GLOBAL, SRC_LOCAL, SRC_OFF6, SRC_OFF7} clkSrc_t;
    typedef logic [31:0] word_t;
endpackage

// File: sim/pterm_block_props.sv
// Checker of bus timing, clears and enables of the macrocell block
`timescale 1ns/1ns
`include "pterm_regs_regs.svh"
module pterm_block_props
(
    // Clock and reset
    input wire logic             core_clk,
    input wire logic             sys_rst,
    // Bus
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [11:0]      adr_i,
    input wire pterm_pkg::word_t dat_i,
    input wire pterm_pkg::word_t dat_o,
    input wire logic             ack_o,
    // Controls and outputs
    input wire logic [1:0]       blockClockEnable,
    input wire logic             globalClr,
    input wire logic [1:0]       localClr,
    input wire logic             deviceWideReset_n,
    input wire logic [15:0]      mcOut
);
    import pterm_pkg::*;
    logic [31:0] blk_q;
    logic [31:0] mc0_q;
    logic        req;
    logic        block_async_clear_one;
    logic        devRst;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Shadow config, taken at the accepting edge as the design does
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            blk_q <= 32'h0;
            mc0_q <= 32'h0;
        end
        else if (cyc_i && stb_i && we_i && ack_o)
        begin
            if (adr_i == `OFS_BLK)
                blk_q <= dat_i;
            if (adr_i == `OFS_MC)
                mc0_q <= dat_i;
        end
    end
    assign req = cyc_i && stb_i && !ack_o;
    assign block_async_clear_one = (mc0_q[5:4] == 2'h1) && ((blk_q[8] ? localClr[0] : globalClr) ^ blk_q[9]);
    assign devRst = blk_q[12] && !deviceWideReset_n;
    ////////////////////////////////////////
    a_ack_timing: assert property (req |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_cause: assert property (ack_o |-> $past(req)) else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !ack_o && mcOut == 16'h0000)
        else $error("outputs live in reset");
    a_stat_mirror: assert property (req && !we_i && adr_i == `OFS_STAT |=>
        dat_o[15:0] == mcOut || dat_o[15:0] == $past(mcOut)) else $error("status not outputs");
    a_devrst_zero: assert property (devRst [*6] |-> mcOut == 16'h0000) else $error("device reset lost");
    a_clear_one: assert property ((block_async_clear_one && !mc0_q[2]) [*6] |-> !mcOut[0]) else $error("clear lost");
    a_enable_gates: assert property ((!mc0_q[2] && !mc0_q[3] && mc0_q[5:4] != 2'h2 && !blockClockEnable[0]
        && !block_async_clear_one && !devRst) [*8] |-> $stable(mcOut[0])) else $error("update while disabled");
    c_write: cover property (cyc_i && stb_i && we_i && ack_o);
    c_devrst: cover property (devRst [*6]);
    c_clear: cover property (block_async_clear_one [*6]);
endmodule

bind product_term_macrocell_block pterm_block_props u_props
(
    .core_clk(core_clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .blockClockEnable(blockClockEnable), .globalClr(globalClr),
    .localClr(localClr), .deviceWideReset_n(deviceWideReset_n), .mcOut(mcOut)
);

// File: sim/routing_model.sv
// Far-side routing model: pulses the global clock source on request
`timescale 1ns/1ns
module routing_model
(
    // Clock
    input  wire logic       core_clk,
    // Request and level length in core cycles
    input  wire logic       pulseReq,
    input  wire logic [3:0] levelLen,
    // Clock source
    output logic            globalClk,
    output logic            busy
);
    int cnt = 0;
    initial
    begin
        globalClk = 1'b0;
        busy = 1'b0;
    end
    // Each level held levelLen cycles, not clamped; the bench never asks under two, so the samplers see it
    always @(posedge core_clk)
    begin
        if (!busy && pulseReq)
        begin
            busy <= 1'b1;
            cnt <= 2 * levelLen;
            globalClk <= 1'b1;
        end
        else if (busy)
        begin
            cnt <= cnt - 1;
            if (cnt == levelLen + 1)
                globalClk <= 1'b0;
            if (cnt == 1)
                busy <= 1'b0;
        end
    end
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the product-term macrocell block
`timescale 1ns/1ns
`include "pterm_regs_regs.svh"
module tb_top;
    import pterm_pkg::*;
    logic        core_clk, sys_rst, cyc_i, stb_i, we_i, ack_o, globalClk, globalClr;
    logic        deviceWideReset_n, pulseReq, busy, q;
    logic [11:0] adr_i;
    logic [3:0]  sel_i, levelLen;
    logic [1:0]  blockClockEnable;
    logic [31:0] routeIn;
    logic [15:0] mcOut;
    word_t       dat_i, dat_o, rd, wv;
    int          fails, checks_done, cycles;
    logic [11:0] addrs[$] = '{`OFS_MC, `OFS_BLK, `OFS_TRUE, `OFS_COMP, `OFS_STAT, 12'h148};

    product_term_macrocell_block u_dut
    (
        .core_clk(core_clk), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .routeIn(routeIn),
        .dedicatedClk({globalClk, 3'h0}),
        .globalClk(globalClk), .localClk(2'h0), .blockClockEnable(blockClockEnable), .globalClr(globalClr),
        .localClr(2'h0), .deviceWideReset_n(deviceWideReset_n), .mcOut(mcOut)
    );
    routing_model u_far
    (
        .core_clk(core_clk), .pulseReq(pulseReq), .levelLen(levelLen), .globalClk(globalClk), .busy(busy)
    );
    ////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk_word(input string what, input word_t exp, input word_t got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_out(input string what, input logic exp);
        checks_done++;
        if (mcOut[0] !== exp)
        begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, exp, mcOut[0]);
        end
    endtask
    // Request held until ack is sampled high, data taken at that edge
    // No cycle count assumed; only the bench timeout ends a hang
    task automatic wb(input logic wr, input logic [11:0] a, input word_t d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= a;
        dat_i <= d;
        do
            @(posedge core_clk);
        while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pulse(input logic [3:0] len);
        levelLen <= len;
        pulseReq <= 1'b1;
        @(posedge core_clk);
        pulseReq <= 1'b0;
        do
            @(posedge core_clk);
        while (busy === 1'b1);
        repeat (8) @(posedge core_clk);
    endtask
    // Both terms high: D sets, T and JK toggle, SR holds
    function automatic logic nextQ(input int t, input logic v);
        case (t)
            0: return 1'b1;
            3: return v;
            default: return !v;
        endcase
    endfunction
    ////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        {sys_rst, cyc_i, stb_i, we_i, globalClr, pulseReq, deviceWideReset_n} = 7'b1000001;
        {adr_i, sel_i, levelLen, blockClockEnable, routeIn, dat_i, cycles} = '0;
        sel_i = 4'hf;
        rd = $urandom(32'hd95f5e28);
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        wb(1, 12'h148, 32'hffffffff);
        wb(1, `OFS_STAT, 32'hffffffff);
        foreach (addrs[i])
        begin
            wb(0, addrs[i], 32'h0);
            chk_word("reset value", 32'h0, rd);
        end
        wv = $urandom & 32'h1fff;
        wb(1, `OFS_MC, wv);
        wb(0, `OFS_MC, 32'h0);
        chk_word("control readback", wv, rd);
        $display("test registers done");
        // Own terms forced low, sum comes only from the terms borrowed from macrocells one and two
        for (int k = 0; k < 4; k++)
            wb(1, `OFS_TRUE + 12'h80 * k[1] + 12'h4 * k[0], 32'h1);
        wb(1, `OFS_TRUE + 12'h8, 32'h20);
        wb(1, `OFS_TRUE + 12'h10, 32'h40);
        wb(1, `OFS_MC + 12'h8, 32'h40);
        wb(1, `OFS_MC + 12'h4, 32'h840);
        wb(1, `OFS_MC, 32'h404);
        repeat (6)
        begin
            routeIn <= $urandom;
            repeat (8) @(posedge core_clk);
            chk_out("expander sum", routeIn[5] | routeIn[6]);
        end
        routeIn <= 32'h0;
        wb(1, `OFS_MC, 32'h704);
        repeat (8) @(posedge core_clk);
        chk_out("inverted term", 1'b1);
        $display("test combinational done");
        for (int k = 0; k < 4; k++)
            wb(1, `OFS_TRUE + 12'h80 * k[1] + 12'h4 * k[0], 32'h0);
        wb(1, `OFS_BLK, 32'h4);
        blockClockEnable <= 2'h1;
        for (int t = 0; t < 4; t++)
        begin
            wb(1, `OFS_MC, 32'h10 | t);
            globalClr <= 1'b1;
            repeat (8) @(posedge core_clk);
            q = 1'b0;
            chk_out("cleared", q);
            globalClr <= 1'b0;
            repeat (4) @(posedge core_clk);
            for (int p = 0; p < 2; p++)
            begin
                pulse(p ? 4'h5 : 4'h2);
                q = nextQ(t, q);
                chk_out("register type", q);
            end
        end
        wb(1, `OFS_MC, 32'h10);
        blockClockEnable <= 2'h0;
        pulse(4'h2);
        chk_out("enable low", 1'b0);
        wb(1, `OFS_BLK, 32'hc4);
        wb(1, `OFS_MC, 32'h18);
        blockClockEnable <= 2'h2;
        pulse(4'h3);
        chk_out("falling clock two", 1'b1);
        // Pin three carries the pulses; a wrong pin index never ticks
        wb(1, `OFS_BLK, 32'h3);
        wb(1, `OFS_MC, 32'h11);
        blockClockEnable <= 2'h1;
        pulse(4'h2);
        chk_out("dedicated clock", 1'b0);
        // Term zero is the inverse of output zero fed back: toggles per pulse
        wb(1, `OFS_COMP, 32'h1);
        wb(1, `OFS_BLK, 32'h10004);
        wb(1, `OFS_MC, 32'h90);
        for (int p = 0; p < 2; p++)
        begin
            pulse(4'h2);
            chk_out("feedback", p == 0);
        end
        $display("test register done");
        wb(1, `OFS_BLK, 32'h2c4);
        repeat (8) @(posedge core_clk);
        chk_out("inverted clear", 1'b0);
        wb(0, `OFS_STAT, 32'h0);
        chk_word("clear status", 32'h10000, rd & 32'h10000);
        wb(1, `OFS_BLK, 32'h10c4);
        pulse(4'h2);
        deviceWideReset_n <= 1'b0;
        pulse(4'h2);
        chk_word("device reset", 32'h0, {16'h0, mcOut});
        deviceWideReset_n <= 1'b1;
        $display("test clears done");
        stop_test();
    end
endmodule
